// *** design/txicp_top.sv ***
// Control cell template store, transfer engine, cell builder and link control
// How it works
// R01 - Eight group templates of 32 sixteen-bit words from word 0x0500.
// R02 - Templates reach internal memory only when software issues the transfer command.
// R03 - Software initialises every template word before running the group.
// R04 - Software sets header bytes one to three to 0x00, byte four 0x0B.
// R05 - HEC is always computed and inserted, template byte ignored.
// R06 - Software sets the OAM label byte to 0x01 or 0x03.
// R07 - Cell type bit driven by device; link identifier from per-link register.
// R08 - Current frame sequence number inserted into each cell.
// R09 - Cell offset inserted from the per-link offset register.
// R10 - Link stuff indication byte inserted by the device.
// R11 - Change indication inserted; group identifier sent as written.
// R12 - Group status byte sent from template; sync information inserted.
// R13 - Test control and both test pattern bytes sent as written.
// R14 - Link status bytes follow identifier order, packed as the template holds them.
// R15 - Software writes 0x6A into the unused byte after link 31 status.
// R16 - End-to-end byte sent as written; CRC-10 split into last two bytes.
// R17 - Sixteen transmit link control registers from word 0x0600.
// R18 - Bits 14:10 select transmit link clock source; zero picks receive clock zero.
// R19 - Bit 15 of link control reads zero.
// R20 - Bit 9 sets transmit link clock direction: zero drives, one input.
// R21 - CRC-10 over 48 payload bytes, generator 0x633, CRC field zero.
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module txicp_top (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire txicp_pkg::txicp_req_t cell_req_i,
   input wire logic cell_req_valid_i,
   output logic cell_busy_o,
   output txicp_pkg::txicp_beat_t cell_beat_o,
   output logic [15:0][4:0] tx_link_clock_sel_o,
   output logic [15:0] tx_link_clock_in_o
);
   import txicp_pkg::*;

   function automatic logic [7:0] hec_step(input logic [7:0] crc, input logic [7:0] b);
      logic [7:0] c;
      c = crc;
      for (int i = 7; i >= 0; i--) begin
         if (c[7] ^ b[i]) begin
            c = {c[6:0], 1'b0} ^ HEC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

   function automatic logic [9:0] crc10_step(input logic [9:0] crc, input logic [7:0] b);
      logic [9:0] c;
      c = crc;
      for (int i = 7; i >= 0; i--) begin
         if (c[9] ^ b[i]) begin
            c = {c[8:0], 1'b0} ^ CRC10_POLY;
         end else begin
            c = {c[8:0], 1'b0};
         end
      end
      return c;
   endfunction

   function automatic logic in_range(input logic [11:0] idx, input logic [11:0] lo,
                                     input logic [11:0] hi);
      return (idx >= lo) && (idx <= hi);
   endfunction

   // Storage
   logic [15:0] shadow_mem [MEM_WORDS];
   logic [15:0] cell_mem [MEM_WORDS];
   logic [14:0] link_ctrl [LINKS];
   logic [4:0] link_id [LINKS];
   logic [7:0] link_ofs [LINKS];

   // Bus decode
   logic [11:0] bus_idx;
   logic bus_aligned;
   logic hit_tmpl;
   logic hit_ctrl;
   logic hit_cmd;
   logic hit_lid;
   logic hit_ofs;
   logic hit_any;
   logic bus_setup;
   logic bus_write;
   logic [3:0] link_sel;
   logic [7:0] mem_sel;

   assign bus_idx = paddr_i[13:2];
   assign bus_aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[15:14] == 2'b00);
   assign hit_tmpl = bus_aligned && in_range(bus_idx, TMPL_BASE, TMPL_LAST); // [R01]
   assign hit_ctrl = bus_aligned && in_range(bus_idx, CTRL_BASE, CTRL_LAST); // [R17]
   assign hit_cmd = bus_aligned && (bus_idx == XFER_CMD);
   assign hit_lid = bus_aligned && in_range(bus_idx, LID_BASE, LID_LAST);
   assign hit_ofs = bus_aligned && in_range(bus_idx, OFS_BASE, OFS_LAST);
   assign hit_any = hit_tmpl || hit_ctrl || hit_cmd || hit_lid || hit_ofs;
   assign bus_setup = psel_i && !penable_i;
   assign bus_write = psel_i && penable_i && pready_o && pwrite_i && hit_any;
   assign link_sel = bus_idx[3:0];
   assign mem_sel = bus_idx[7:0];

   // Transfer engine state
   txicp_copy_t copy_state;
   logic [2:0] copy_group;
   logic [4:0] copy_word;

   // APB answer: one wait-free access phase, answer prepared in the setup cycle
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= bus_setup;
         pslverr_o <= bus_setup && !hit_any;
         if (bus_setup && !pwrite_i) begin
            if (hit_tmpl) begin
               prdata_o <= {16'h0000, shadow_mem[mem_sel]};
            end else if (hit_ctrl) begin
               prdata_o <= {17'h00000, link_ctrl[link_sel]}; // [R19]
            end else if (hit_cmd) begin
               prdata_o <= {16'h0000, (copy_state == COPY_RUN), 12'h000, copy_group};
            end else if (hit_lid) begin
               prdata_o <= {27'h0000000, link_id[link_sel]};
            end else if (hit_ofs) begin
               prdata_o <= {24'h000000, link_ofs[link_sel]};
            end else begin
               prdata_o <= 32'h0000_0000;
            end
         end
      end
   end

   // Template words as software writes them; no reset, software must fill them
   always_ff @(posedge sys_clk_i) begin
      if (bus_write && hit_tmpl) begin
         shadow_mem[mem_sel] <= pwdata_i[15:0]; // [R01] [R03]
      end
   end

   // Per-link registers
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < LINKS; i++) begin
            link_ctrl[i] <= CTRL_RESET;
            link_id[i] <= LID_RESET;
            link_ofs[i] <= OFS_RESET;
         end
      end else if (bus_write) begin
         if (hit_ctrl) begin
            link_ctrl[link_sel] <= pwdata_i[14:0]; // [R17]
         end
         if (hit_lid) begin
            link_id[link_sel] <= pwdata_i[4:0];
         end
         if (hit_ofs) begin
            link_ofs[link_sel] <= pwdata_i[7:0];
         end
      end
   end

   // Clock source and direction go out straight from the control flops
   always_comb begin
      for (int i = 0; i < LINKS; i++) begin
         tx_link_clock_sel_o[i] = link_ctrl[i][CLK_SEL_HI:CLK_SEL_LO]; // [R18]
         tx_link_clock_in_o[i] = link_ctrl[i][CLK_DIR_BIT]; // [R20]
      end
   end

   // Transfer engine: one word per cycle; a command while busy is ignored
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         copy_state <= COPY_IDLE;
         copy_group <= 3'h0;
         copy_word <= 5'h00;
      end else begin
         case (copy_state)
            COPY_IDLE: begin
               if (bus_write && hit_cmd && pwdata_i[CMD_GO_BIT]) begin
                  copy_state <= COPY_RUN; // [R02]
                  copy_group <= pwdata_i[2:0];
                  copy_word <= 5'h00;
               end
            end
            COPY_RUN: begin
               copy_word <= copy_word + 5'h01;
               if (copy_word == 5'h1f) begin
                  copy_state <= COPY_IDLE;
               end
            end
            default: begin
               copy_state <= COPY_IDLE;
            end
         endcase
      end
   end

   // A cell built during a copy of its own group may mix old and new words
   always_ff @(posedge sys_clk_i) begin
      if (copy_state == COPY_RUN) begin
         cell_mem[{copy_group, copy_word}] <= shadow_mem[{copy_group, copy_word}]; // [R02]
      end
   end

   // Cell builder
   txicp_cell_t cell_state;
   txicp_req_t req;
   logic [5:0] byte_num;
   logic [7:0] hec;
   logic [9:0] crc;
   logic [15:0] cur_word;
   logic [7:0] raw_byte;
   logic [7:0] out_byte;
   logic [7:0] crc_hi_zero;
   logic [9:0] crc_full;
   logic [4:0] word_sel;
   logic [5:0] byte_prev;

   assign byte_prev = byte_num - 6'd1;
   assign word_sel = byte_prev[5:1];
   assign cur_word = cell_mem[{req.group, word_sel}];
   assign raw_byte = byte_num[0] ? cur_word[7:0] : cur_word[15:8]; // [R14]
   assign crc_hi_zero = {raw_byte[7:2], 2'b00};
   assign crc_full = crc10_step(crc10_step(crc, crc_hi_zero), 8'h00); // [R21]

   // Byte substitution; every byte not named here is sent as the template holds it
   always_comb begin
      case (byte_num)
         BYTE_HEC: out_byte = hec ^ HEC_COSET; // [R05]
         BYTE_CELL_LINK: out_byte = {req.cell_type, raw_byte[6:5], link_id[req.link]}; // [R07]
         BYTE_FSN: out_byte = req.fsn; // [R08]
         BYTE_OFFSET: out_byte = link_ofs[req.link]; // [R09]
         BYTE_STUFF: out_byte = req.stuff; // [R10]
         BYTE_CHANGE: out_byte = req.change; // [R11]
         BYTE_SYNC: out_byte = req.sync; // [R12]
         BYTE_CRC_HI: out_byte = {raw_byte[7:2], crc_full[9:8]}; // [R16]
         BYTE_CRC_LO: out_byte = crc[7:0]; // [R16]
         default: out_byte = raw_byte; // [R11] [R12] [R13] [R14]
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cell_state <= CELL_IDLE;
         req <= '0;
         byte_num <= 6'd1;
         cell_busy_o <= 1'b0;
      end else begin
         case (cell_state)
            CELL_IDLE: begin
               byte_num <= 6'd1;
               if (cell_req_valid_i) begin
                  cell_state <= CELL_SEND;
                  req <= cell_req_i;
                  cell_busy_o <= 1'b1;
               end
            end
            CELL_SEND: begin
               byte_num <= byte_num + 6'd1;
               if (byte_num == BYTE_CRC_LO) begin
                  cell_state <= CELL_IDLE;
                  cell_busy_o <= 1'b0;
               end
            end
            default: begin
               cell_state <= CELL_IDLE;
               cell_busy_o <= 1'b0;
            end
         endcase
      end
   end

   // Running checksums; the HEC only sees the four header bytes
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         hec <= 8'h00;
         crc <= 10'h000;
      end else if (cell_state != CELL_SEND) begin
         hec <= 8'h00;
         crc <= 10'h000;
      end else begin
         if (byte_num < BYTE_HEC) begin
            hec <= hec_step(hec, raw_byte); // [R05]
         end
         if ((byte_num >= BYTE_PAY_FIRST) && (byte_num < BYTE_CRC_HI)) begin
            crc <= crc10_step(crc, out_byte); // [R21]
         end else if (byte_num == BYTE_CRC_HI) begin
            crc <= crc_full; // [R21]
         end
      end
   end

   // Output beat, registered
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cell_beat_o <= '0;
      end else begin
         cell_beat_o.valid <= (cell_state == CELL_SEND);
         cell_beat_o.sop <= (cell_state == CELL_SEND) && (byte_num == 6'd1);
         cell_beat_o.eop <= (cell_state == CELL_SEND) && (byte_num == BYTE_CRC_LO);
         cell_beat_o.data <= (cell_state == CELL_SEND) ? out_byte : 8'h00;
      end
   end
endmodule

// *** design/txicp_pkg.sv ***
// Constants and carrier types for the transmit control cell template store
package txicp_pkg;
   // Register word indices; byte address is four times the index
   localparam logic [11:0] TMPL_BASE = 12'h500;
   localparam logic [11:0] TMPL_LAST = 12'h5ff;
   localparam logic [11:0] CTRL_BASE = 12'h600;
   localparam logic [11:0] CTRL_LAST = 12'h60f;
   localparam logic [11:0] XFER_CMD = 12'h640;
   localparam logic [11:0] LID_BASE = 12'h650;
   localparam logic [11:0] LID_LAST = 12'h65f;
   localparam logic [11:0] OFS_BASE = 12'h660;
   localparam logic [11:0] OFS_LAST = 12'h66f;
   localparam int GROUPS = 8;
   localparam int TMPL_WORDS = 32;
   localparam int LINKS = 16;
   localparam int MEM_WORDS = GROUPS * TMPL_WORDS;
   // Field positions and reset values
   localparam int CLK_SEL_HI = 14;
   localparam int CLK_SEL_LO = 10;
   localparam int CLK_DIR_BIT = 9;
   localparam int CMD_GO_BIT = 8;
   localparam int CMD_BUSY_BIT = 15;
   localparam logic [14:0] CTRL_RESET = 15'h0000;
   localparam logic [4:0] LID_RESET = 5'h00;
   localparam logic [7:0] OFS_RESET = 8'h00;
   // Cell byte numbers, counted from one
   localparam logic [5:0] BYTE_HEC = 6'd5;
   localparam logic [5:0] BYTE_PAY_FIRST = 6'd6;
   localparam logic [5:0] BYTE_CELL_LINK = 6'd7;
   localparam logic [5:0] BYTE_FSN = 6'd8;
   localparam logic [5:0] BYTE_OFFSET = 6'd9;
   localparam logic [5:0] BYTE_STUFF = 6'd10;
   localparam logic [5:0] BYTE_CHANGE = 6'd11;
   localparam logic [5:0] BYTE_SYNC = 6'd14;
   localparam logic [5:0] BYTE_CRC_HI = 6'd52;
   localparam logic [5:0] BYTE_CRC_LO = 6'd53;
   // Checksums
   localparam logic [7:0] HEC_POLY = 8'h07;
   localparam logic [7:0] HEC_COSET = 8'h55;
   localparam logic [9:0] CRC10_POLY = 10'h233;

   typedef struct packed {
      logic [2:0] group;
      logic [3:0] link;
      logic cell_type;
      logic [7:0] fsn;
      logic [7:0] stuff;
      logic [7:0] change;
      logic [7:0] sync;
   } txicp_req_t;

   typedef struct packed {
      logic valid;
      logic sop;
      logic eop;
      logic [7:0] data;
   } txicp_beat_t;

   typedef enum logic [1:0] {
      COPY_IDLE = 2'b01,
      COPY_RUN = 2'b10
   } txicp_copy_t;

   typedef enum logic [1:0] {
      CELL_IDLE = 2'b01,
      CELL_SEND = 2'b10
   } txicp_cell_t;
endpackage

// *** bench/txicp_chk.sv ***
// Concurrent checks on the ports of the control cell template store
`timescale 1ns/10ps
module txicp_chk (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic cell_req_valid_i,
   input wire logic cell_busy_o,
   input wire txicp_pkg::txicp_beat_t cell_beat_o,
   input wire logic [15:0][4:0] tx_link_clock_sel_o,
   input wire logic [15:0] tx_link_clock_in_o
);
   import txicp_pkg::*;
   logic [5:0] beat_n;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Counts beats since start of cell; too long for a repetition
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) beat_n <= 6'h00;
      else if (cell_beat_o.sop) beat_n <= 6'h01;
      else if (cell_beat_o.valid) beat_n <= beat_n + 6'h01;
      else beat_n <= 6'h00;
   end
   sequence s_take;
      cell_req_valid_i && !cell_busy_o;
   endsequence
   sequence s_start;
      cell_busy_o && !cell_beat_o.valid ##1 cell_beat_o.valid && cell_beat_o.sop;
   endsequence
   property p_start;
      s_take |=> s_start;
   endproperty
   a_start: assert property (p_start) else $error("cell did not start on time");
   property p_len;
      cell_beat_o.eop |-> cell_beat_o.valid && beat_n == 6'd52;
   endproperty
   a_len: assert property (p_len) else $error("cell length wrong");
   property p_run;
      cell_beat_o.valid && !cell_beat_o.eop |=> cell_beat_o.valid && !cell_beat_o.sop;
   endproperty
   a_run: assert property (p_run) else $error("cell beats broken");
   property p_busy_fall;
      cell_beat_o.eop |-> !cell_busy_o && $past(cell_busy_o);
   endproperty
   a_busy_fall: assert property (p_busy_fall) else $error("busy not ending at last byte");
   property p_rdy_setup;
      psel_i && !penable_i |=> pready_o;
   endproperty
   a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
   property p_rdy_one;
      pready_o |=> !pready_o;
   endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
   property p_err;
      pslverr_o |-> pready_o;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_bit15;
      pready_o && !pslverr_o && !pwrite_i && paddr_i[13:6] == 8'h60 |-> prdata_o[15] == 1'b0;
   endproperty
   a_bit15: assert property (p_bit15) else $error("link control bit 15 set");
   property p_ctrl_wr;
      pready_o && penable_i && pwrite_i && !pslverr_o && paddr_i[13:6] == 8'h60 |=>
         tx_link_clock_sel_o[$past(paddr_i[5:2])] == $past(pwdata_i[14:10]) &&
         tx_link_clock_in_o[$past(paddr_i[5:2])] == $past(pwdata_i[9]);
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("clock outputs not updated");
endmodule
bind txicp_top txicp_chk chk (.sys_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cell_req_valid_i, .cell_busy_o, .cell_beat_o,
   .tx_link_clock_sel_o, .tx_link_clock_in_o);

// *** bench/txicp_top_bench.sv ***
// Self-checking bench for the control cell template store
`timescale 1ns/10ps
module txicp_top_bench;
   import txicp_pkg::*;
   logic sys_clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [15:0] paddr_i = 16'h0000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, r;
   logic pready_o, pslverr_o, cell_req_valid_i = 1'b0, cell_busy_o, e;
   txicp_req_t cell_req_i = '0;
   txicp_beat_t cell_beat_o;
   logic [15:0][4:0] tx_link_clock_sel_o;
   logic [15:0] tx_link_clock_in_o;
   logic [15:0] tmpl [32];
   logic [7:0] cap [54];
   logic [7:0] ex [54];
   logic [9:0] c;
   int err_count = 0, cmp_count = 0, cap_n = 0;
   txicp_top dut (.sys_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .cell_req_i, .cell_req_valid_i, .cell_busy_o,
      .cell_beat_o, .tx_link_clock_sel_o, .tx_link_clock_in_o);
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // Extra beats past 53 are counted so a second cell shows up
   always @(posedge sys_clk_i) begin
      if (cell_beat_o.valid === 1'b1) begin
         if (cap_n < 53) cap[cap_n + 1] = cell_beat_o.data;
         cap_n++;
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= {2'b00, idx, 2'b00};
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      // No cycle count assumed; the watchdog ends a wait that never completes
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // Waits half a cycle so register outputs have settled
   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
      @(negedge sys_clk_i);
   endtask
   task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(r, exp);
   endtask
   function automatic logic [9:0] crcb(logic [9:0] s, logic [7:0] b, logic [9:0] p, int w);
      logic fb;
      for (int i = 7; i >= 0; i--) begin
         fb = s[w - 1] ^ b[i];
         s = (s << 1) & ((10'h001 << w) - 10'h001);
         if (fb) s = s ^ p;
      end
      return s;
   endfunction
   task automatic close_out;
      $display("Compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #500000;
      err_count++;
      close_out;
   end
   initial begin
      repeat (10) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      rd(12'h603, 32'h0);
      wr(12'h605, 32'hffff_ffff);
      rd(12'h605, 32'h0000_7fff);
      check(32'(tx_link_clock_sel_o[5]), 32'h1f);
      wr(12'h605, 32'h0000_0200);
      check(32'(tx_link_clock_sel_o[5]), 32'h0);
      check(32'(tx_link_clock_in_o), 32'h0020);
      wr(12'h605, 32'h0);
      check(32'(tx_link_clock_in_o[5]), 32'h0);
      apb(1'b0, 12'h700, 32'h0);
      check(32'(e), 32'h1);
      apb(1'b0, 12'h4ff, 32'h0);
      check(32'(e), 32'h1);
      for (int w = 0; w < 32; w++)
         tmpl[w] = {8'h80 + 8'(2 * w), 8'h11 + 8'(2 * w)};
      tmpl[0] = 16'h0000;
      tmpl[1] = 16'h0b00;
      tmpl[2] = 16'h03a5;
      tmpl[24][15:8] = 8'h6a;
      for (int w = 0; w < 32; w++)
         wr(12'h560 + 12'(w), {16'h0000, tmpl[w]});
      wr(12'h653, 32'h0000_000d);
      rd(12'h653, 32'h0000_000d);
      wr(12'h663, 32'h0000_0027);
      rd(12'h663, 32'h0000_0027);
      wr(12'h640, 32'h0000_0103);
      r = 32'h0000_8000;
      for (int k = 0; k < 40 && r[15]; k++)
         apb(1'b0, 12'h640, 32'h0);
      check(r, 32'h0000_0003);
      // Written after the copy, so the cell must still carry the old word
      wr(12'h567, 32'h0000_1234);
      rd(12'h567, 32'h0000_1234);
      @(posedge sys_clk_i);
      cell_req_i <= '{3'd3, 4'd3, 1'b1, 8'h9c, 8'h33, 8'h44, 8'h55};
      cell_req_valid_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      cell_req_valid_i <= 1'b0;
      for (int k = 0; k < 100 && cap_n < 53; k++)
         @(posedge sys_clk_i);
      repeat (8) @(posedge sys_clk_i);
      check(cap_n, 32'd53);
      for (int b = 1; b < 54; b++)
         ex[b] = b[0] ? tmpl[(b - 1) / 2][7:0] : tmpl[(b - 1) / 2][15:8];
      c = 10'h000;
      for (int b = 1; b < 5; b++)
         c = crcb(c, ex[b], 10'h007, 8);
      ex[5] = c[7:0] ^ 8'h55;
      ex[7] = {1'b1, ex[7][6:5], 5'h0d};
      ex[8] = 8'h9c;
      ex[9] = 8'h27;
      ex[10] = 8'h33;
      ex[11] = 8'h44;
      ex[14] = 8'h55;
      ex[52][1:0] = 2'b00;
      ex[53] = 8'h00;
      c = 10'h000;
      for (int b = 6; b < 54; b++)
         c = crcb(c, ex[b], 10'h233, 10);
      ex[52][1:0] = c[9:8];
      ex[53] = c[7:0];
      for (int b = 1; b < 54; b++)
         check(32'(cap[b]), 32'(ex[b]));
      close_out;
   end
endmodule
